// *** sci_irq_pkg.sv ***
// Shared constants for the serial interface interrupt and flag block.
// Assumes a single aclk domain and an AXI4-Lite register port.
package sci_irq_pkg;
  localparam int NUM_CHAN = 4;
  // Per-channel register window, 16 bytes each
  localparam logic [7:0] CHAN_STRIDE = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0c;
  localparam logic [7:0] OFS_STANDBY = 8'h40;
  // Control bit positions
  localparam int CB_TIE = 0;
  localparam int CB_RIE = 1;
  localparam int CB_TX_END_IRQ_ENABLE = 2;
  localparam int CB_TE = 3;
  localparam int CB_RE = 4;
  localparam int CB_SMART = 5;
  localparam int CB_BLOCK = 6;
  localparam int CB_SYNC = 7;
  localparam int CB_EXTCLK = 8;
  localparam int CTRL_W = 9;
  // Status bit positions
  localparam int SB_TX_DATA_EMPTY_FLAG = 0;
  localparam int SB_TX_END_FLAG = 1;
  localparam int SB_RX_DATA_FULL_FLAG = 2;
  localparam int SB_OVERRUN_ERROR_FLAG = 3;
  localparam int SB_PER = 4;
  localparam int SB_FER = 5;
  localparam int SB_ERS = 6;
  localparam int STAT_W = 7;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
  localparam logic [STAT_W-1:0] STAT_RESET = 7'h03;
  localparam logic STANDBY_RESET = 1'b1;
  // Receive copy windows in aclk cycles after the last data edge
  localparam logic [1:0] RX_COPY_EXT = 2'd3;
  localparam logic [1:0] RX_COPY_INT = 2'd2;
  typedef enum logic [1:0] {W_IDLE = 2'b00, W_RESP = 2'b01} wr_state_type;
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_RESP = 2'b01} rd_state_type;
endpackage

// *** chan_link_if.sv ***
// Carrier between the register front end and one channel flag unit.
// Assumes both ends run on the same aclk.
`timescale 1ns/1ps
interface chan_link_if;
  logic [8:0] ctrl;
  logic [6:0] sw_clear;
  logic tx_write;
  logic tx_init;
  logic [6:0] status;
  modport front (output ctrl, output sw_clear, output tx_write, output tx_init, input status);
  modport unit (input ctrl, input sw_clear, input tx_write, input tx_init, output status);
endinterface

// *** sci_chan_flags.sv ***
// Status flags and interrupt request outputs of one serial channel.
// Assumes event strobes are one-cycle pulses on aclk.
`timescale 1ns/1ps
module sci_chan_flags (
  input wire logic aclk,
  input wire logic aresetn,
  chan_link_if.unit link,
  input wire logic tx_load,
  input wire logic tx_done,
  input wire logic rx_full_set,
  input wire logic overrun_error_flag_set,
  input wire logic per_set,
  input wire logic fer_set,
  input wire logic ers_set,
  input wire logic dma_tx_ack,
  input wire logic dma_rx_ack,
  output logic tx_empty_irq,
  output logic tx_end_irq,
  output logic rx_full_irq,
  output logic rx_error_irq
);
  logic [6:0] flag;
  logic [6:0] set_ev;
  logic [6:0] clr_ev;
  logic smart_sel;
  logic tx_src;
  logic err_src;
  // ==========================================
  // Flag set and clear terms
  assign smart_sel = link.ctrl[sci_irq_pkg::CB_SMART] & ~link.ctrl[sci_irq_pkg::CB_BLOCK];
  assign set_ev[sci_irq_pkg::SB_TX_DATA_EMPTY_FLAG] = tx_load | link.tx_init;
  assign set_ev[sci_irq_pkg::SB_TX_END_FLAG] = tx_done | link.tx_init;
  assign set_ev[sci_irq_pkg::SB_RX_DATA_FULL_FLAG] = rx_full_set;
  assign set_ev[sci_irq_pkg::SB_OVERRUN_ERROR_FLAG] = overrun_error_flag_set;
  assign set_ev[sci_irq_pkg::SB_PER] = per_set;
  assign set_ev[sci_irq_pkg::SB_FER] = fer_set;
  assign set_ev[sci_irq_pkg::SB_ERS] = ers_set;
  // Data write or DMA transfer empties the transmit flags
  always_comb
  begin
    clr_ev = link.sw_clear;
    if (link.tx_write | dma_tx_ack)
    begin
      clr_ev[sci_irq_pkg::SB_TX_DATA_EMPTY_FLAG] = 1'b1;
      clr_ev[sci_irq_pkg::SB_TX_END_FLAG] = 1'b1;
    end
    if (dma_rx_ack)
    begin
      clr_ev[sci_irq_pkg::SB_RX_DATA_FULL_FLAG] = 1'b1;
    end
  end
  // ==========================================
  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag <= sci_irq_pkg::STAT_RESET;
    end
    else
    begin
      flag <= (flag & ~clr_ev) | set_ev;
    end
  end
  assign link.status = flag;
  // ==========================================
  // Request outputs, level while flag and enable hold
  assign tx_src = smart_sel ? flag[sci_irq_pkg::SB_TX_END_FLAG] : flag[sci_irq_pkg::SB_TX_DATA_EMPTY_FLAG];
  assign err_src = flag[sci_irq_pkg::SB_OVERRUN_ERROR_FLAG] | flag[sci_irq_pkg::SB_PER] |
    (smart_sel ? flag[sci_irq_pkg::SB_ERS] : flag[sci_irq_pkg::SB_FER]);
  assign tx_empty_irq = tx_src & link.ctrl[sci_irq_pkg::CB_TIE];
  assign rx_full_irq = flag[sci_irq_pkg::SB_RX_DATA_FULL_FLAG] & link.ctrl[sci_irq_pkg::CB_RIE];
  assign rx_error_irq = err_src & link.ctrl[sci_irq_pkg::CB_RIE];
  // End request yields while the empty request is pending
  assign tx_end_irq = flag[sci_irq_pkg::SB_TX_END_FLAG] & link.ctrl[sci_irq_pkg::CB_TX_END_IRQ_ENABLE] &
    ~smart_sel & ~tx_empty_irq;
endmodule

// *** sci_irq_flags.sv ***
// Four-channel serial interface: registers, flags, requests, receive copy.
// Assumes frame shifters outside, pulsing events on aclk; sck pins async.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module sci_irq_flags #(
  parameter int NCH = sci_irq_pkg::NUM_CHAN
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCH-1:0] sck_pin,
  input wire logic [NCH-1:0] int_clk_rise,
  input wire logic [NCH-1:0] rx_last_bit,
  input wire logic [8*NCH-1:0] rx_shift_data,
  input wire logic [NCH-1:0] tx_load,
  input wire logic [NCH-1:0] tx_done,
  input wire logic [NCH-1:0] overrun_error_flag_set,
  input wire logic [NCH-1:0] per_set,
  input wire logic [NCH-1:0] fer_set,
  input wire logic [NCH-1:0] ers_set,
  input wire logic [NCH-1:0] dma_tx_ack,
  input wire logic [8*NCH-1:0] dma_tx_data,
  input wire logic [NCH-1:0] dma_rx_ack,
  output logic [8*NCH-1:0] rx_holding_reg,
  output logic [8*NCH-1:0] tx_holding_reg,
  output logic [NCH-1:0] tx_start_allow,
  output logic [NCH-1:0] tx_init,
  output logic [NCH-1:0] rx_enable,
  output logic [NCH-1:0] sck_rise,
  output logic [NCH-1:0] tx_empty_irq,
  output logic [NCH-1:0] tx_end_irq,
  output logic [NCH-1:0] rx_full_irq,
  output logic [NCH-1:0] rx_error_irq,
  output logic module_standby
);
  sci_irq_pkg::wr_state_type wr_state;
  sci_irq_pkg::rd_state_type rd_state;
  logic [7:0] aw_addr;
  logic aw_got;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_got;
  logic wr_go;
  logic wr_ok;
  logic [1:0] wr_ch;
  logic [3:0] wr_ofs;
  logic [1:0] rd_ch;
  logic [3:0] rd_ofs;
  logic rd_ok;
  logic [31:0] next_rdata;
  logic [8:0] ctrl [NCH];
  logic [6:0] status [NCH];

  // ==========================================
  // Write channel: address and data taken in either order
  assign s_axi_awready = (wr_state == sci_irq_pkg::W_IDLE) & ~aw_got;
  assign s_axi_wready = (wr_state == sci_irq_pkg::W_IDLE) & ~w_got;
  assign wr_go = (wr_state == sci_irq_pkg::W_IDLE) & aw_got & w_got;
  assign wr_ch = aw_addr[5:4];
  assign wr_ofs = aw_addr[3:0];
  // Registers locked while in standby, except the standby bit itself
  assign wr_ok = (aw_addr == sci_irq_pkg::OFS_STANDBY) |
    (~module_standby & (aw_addr[7:6] == 2'b00) & (aw_addr[1:0] == 2'b00));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid & s_axi_awready)
    begin
      aw_got <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_go)
    begin
      aw_got <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid & s_axi_wready)
    begin
      w_got <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_go)
    begin
      w_got <= 1'b0;
    end
  end

  // Response state; SLVERR for unmapped or locked addresses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state <= sci_irq_pkg::W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      case (wr_state)
        sci_irq_pkg::W_IDLE:
        begin
          if (wr_go)
          begin
            wr_state <= sci_irq_pkg::W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
          end
        end
        sci_irq_pkg::W_RESP:
        begin
          if (s_axi_bready)
          begin
            wr_state <= sci_irq_pkg::W_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default:
        begin
          wr_state <= sci_irq_pkg::W_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Module standby, set out of reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      module_standby <= sci_irq_pkg::STANDBY_RESET;
    end
    else if (wr_go & (aw_addr == sci_irq_pkg::OFS_STANDBY) & w_strb[0])
    begin
      module_standby <= w_data[0];
    end
  end

  // ==========================================
  // Read channel, one read in flight
  assign s_axi_arready = (rd_state == sci_irq_pkg::R_IDLE);
  assign rd_ch = s_axi_araddr[5:4];
  assign rd_ofs = s_axi_araddr[3:0];
  assign rd_ok = (s_axi_araddr == sci_irq_pkg::OFS_STANDBY) |
    (~module_standby & (s_axi_araddr[7:6] == 2'b00) & (s_axi_araddr[1:0] == 2'b00));

  // Read mux; upper bits read as zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (s_axi_araddr == sci_irq_pkg::OFS_STANDBY)
    begin
      next_rdata[0] = module_standby;
    end
    else if (rd_ok)
    begin
      case (rd_ofs)
        sci_irq_pkg::OFS_CTRL[3:0]: next_rdata[8:0] = ctrl[rd_ch];
        sci_irq_pkg::OFS_STATUS[3:0]: next_rdata[6:0] = status[rd_ch];
        sci_irq_pkg::OFS_TXDATA[3:0]: next_rdata[7:0] = tx_holding_reg[8*rd_ch +: 8];
        sci_irq_pkg::OFS_RXDATA[3:0]: next_rdata[7:0] = rx_holding_reg[8*rd_ch +: 8];
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state <= sci_irq_pkg::R_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      case (rd_state)
        sci_irq_pkg::R_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            rd_state <= sci_irq_pkg::R_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
          end
        end
        sci_irq_pkg::R_RESP:
        begin
          if (s_axi_rready)
          begin
            rd_state <= sci_irq_pkg::R_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default:
        begin
          rd_state <= sci_irq_pkg::R_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Per-channel control, data, clock sync and flag unit
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_ch
      chan_link_if link ();
      logic sel;
      logic [2:0] sck_sync;
      logic sck_level;
      logic [1:0] copy_cnt;
      logic copy_pend;
      logic [7:0] rx_capt;
      logic rx_edge;
      logic rx_full_set;
      logic any_err;

      assign sel = wr_go & wr_ok & (wr_ch == 2'(ch)) & ~module_standby;

      // Control register; a falling transmit enable pulses the init
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          ctrl[ch] <= sci_irq_pkg::CTRL_RESET;
          tx_init[ch] <= 1'b0;
        end
        else
        begin
          tx_init[ch] <= 1'b0;
          if (sel & (wr_ofs == sci_irq_pkg::OFS_CTRL[3:0]) & (&w_strb[1:0]))
          begin
            ctrl[ch] <= w_data[8:0];
            tx_init[ch] <= ctrl[ch][sci_irq_pkg::CB_TE] & ~w_data[sci_irq_pkg::CB_TE];
          end
        end
      end

      // Holding data: software write or DMA; DMA wins over a write in the same cycle
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          tx_holding_reg[8*ch +: 8] <= 8'h00;
        end
        else if (dma_tx_ack[ch])
        begin
          tx_holding_reg[8*ch +: 8] <= dma_tx_data[8*ch +: 8];
        end
        else if (sel & (wr_ofs == sci_irq_pkg::OFS_TXDATA[3:0]) & w_strb[0])
        begin
          tx_holding_reg[8*ch +: 8] <= w_data[7:0];
        end
      end

      assign link.ctrl = ctrl[ch];
      assign link.tx_init = tx_init[ch];
      assign link.tx_write = sel & (wr_ofs == sci_irq_pkg::OFS_TXDATA[3:0]) & w_strb[0];
      // Status is write-one-to-clear
      assign link.sw_clear = (sel & (wr_ofs == sci_irq_pkg::OFS_STATUS[3:0]) & w_strb[0]) ?
        w_data[6:0] : 7'h00;
      assign status[ch] = link.status;

      // Serial clock pin: three stages, change counts when last two agree
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sck_sync <= 3'b111;
          sck_level <= 1'b1;
        end
        else
        begin
          sck_sync <= {sck_sync[1:0], sck_pin[ch]};
          if (sck_sync[2] == sck_sync[1])
          begin
            sck_level <= sck_sync[1];
          end
        end
      end
      assign sck_rise[ch] = ~sck_level & sck_sync[2] & sck_sync[1];

      // Last data edge from pin clock or internal clock
      assign rx_edge = rx_last_bit[ch] &
        (ctrl[ch][sci_irq_pkg::CB_EXTCLK] ? sck_rise[ch] : int_clk_rise[ch]);

      // Delayed copy into holding; disabling receive in the window skips it
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          copy_pend <= 1'b0;
          copy_cnt <= 2'd0;
          rx_capt <= 8'h00;
        end
        else if (rx_edge & ctrl[ch][sci_irq_pkg::CB_RE])
        begin
          copy_pend <= 1'b1;
          copy_cnt <= ctrl[ch][sci_irq_pkg::CB_EXTCLK] ?
            sci_irq_pkg::RX_COPY_EXT : sci_irq_pkg::RX_COPY_INT;
          rx_capt <= rx_shift_data[8*ch +: 8];
        end
        else if (copy_pend)
        begin
          copy_cnt <= copy_cnt - 2'd1;
          copy_pend <= (copy_cnt != 2'd1) & ctrl[ch][sci_irq_pkg::CB_RE];
        end
      end
      // Full flag still sets when receive is dropped inside the copy window
      assign rx_full_set = copy_pend & ((copy_cnt == 2'd1) | ~ctrl[ch][sci_irq_pkg::CB_RE]);

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          rx_holding_reg[8*ch +: 8] <= 8'h00;
        end
        else if (rx_full_set & ctrl[ch][sci_irq_pkg::CB_RE])
        begin
          rx_holding_reg[8*ch +: 8] <= rx_capt;
        end
      end

      // Transmit start gate; sync mode blocks on receive errors
      assign any_err = status[ch][sci_irq_pkg::SB_OVERRUN_ERROR_FLAG] | status[ch][sci_irq_pkg::SB_PER] |
        status[ch][sci_irq_pkg::SB_FER];
      assign tx_start_allow[ch] = ctrl[ch][sci_irq_pkg::CB_TE] &
        ~status[ch][sci_irq_pkg::SB_TX_DATA_EMPTY_FLAG] &
        ~(ctrl[ch][sci_irq_pkg::CB_SYNC] & any_err);
      assign rx_enable[ch] = ctrl[ch][sci_irq_pkg::CB_RE];

      sci_chan_flags u_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .link(link.unit),
        .tx_load(tx_load[ch]),
        .tx_done(tx_done[ch]),
        .rx_full_set(rx_full_set),
        .overrun_error_flag_set(overrun_error_flag_set[ch]),
        .per_set(per_set[ch]),
        .fer_set(fer_set[ch]),
        .ers_set(ers_set[ch]),
        .dma_tx_ack(dma_tx_ack[ch]),
        .dma_rx_ack(dma_rx_ack[ch]),
        .tx_empty_irq(tx_empty_irq[ch]),
        .tx_end_irq(tx_end_irq[ch]),
        .rx_full_irq(rx_full_irq[ch]),
        .rx_error_irq(rx_error_irq[ch])
      );
    end
  endgenerate
endmodule

// *** sci_irq_flags_asserts.sv ***
// Checker for the serial flag block, watching only its top ports.
// Assumes one aclk domain with synchronous active-low reset.
`timescale 1ns/1ps
module sci_irq_flags_asserts #(
  parameter int NCH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [NCH-1:0] tx_load,
  input wire logic [NCH-1:0] tx_init,
  input wire logic [NCH-1:0] tx_start_allow,
  input wire logic [NCH-1:0] overrun_error_flag_set,
  input wire logic [NCH-1:0] dma_rx_ack,
  input wire logic [NCH-1:0] tx_empty_irq,
  input wire logic [NCH-1:0] tx_end_irq,
  input wire logic [NCH-1:0] rx_full_irq,
  input wire logic [NCH-1:0] rx_error_irq,
  input wire logic module_standby
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Register port
  standby_reset_a: assert property ($rose(aresetn) |-> module_standby)
    else $error("standby not set after reset");
  // Both channels taken at one edge: latched next cycle, answered the cycle after
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  // ==========================================
  // Channel 0 flags and requests
  end_masked_a: assert property (tx_end_irq[0] |-> !tx_empty_irq[0])
    else $error("end request beside empty request");
  load_stops_start_a: assert property (tx_load[0] || tx_init[0] |=> !tx_start_allow[0])
    else $error("start allowed with empty flag set");
  // Both write readys high means no register write lands at this edge
  full_held_a: assert property (rx_full_irq[0] && !dma_rx_ack[0] && s_axi_awready
    && s_axi_wready |=> rx_full_irq[0]) else $error("full request dropped");
  error_raise_a: assert property (overrun_error_flag_set[0] && rx_full_irq[0] && s_axi_awready
    && s_axi_wready |=> rx_error_irq[0]) else $error("error request missing");
  cover property (tx_end_irq[0]);
  cover property (rx_full_irq[0]);
  cover property (tx_init[0]);
endmodule

// *** serial_peer.sv ***
// Model of a clocked serial peer driving one channel's clock and data.
// Assumes the bench raises go once per frame, well apart.
`timescale 1ns/1ps
module serial_peer (
  input wire logic go,
  input wire logic [7:0] byte_in,
  output logic sck,
  output logic last,
  output logic [7:0] data
);
  // ==========================================
  // Idle: clock parked high, data not valid
  initial
  begin
    sck = 1'b1;
    last = 1'b0;
    data = 8'h5a;
  end
  // Frame of eight 80 ns clocks; data shows the byte only in the last bit
  always @(posedge go)
  begin
    #22; // Over five aclk cycles, and off the sampling edge
    for (int i = 0; i < 8; i++)
    begin
      sck = 1'b0;
      last = (i == 7);
      data = (i == 7) ? byte_in : ~byte_in;
      #40;
      sck = 1'b1;
      #40;
    end
    last = 1'b0;
    data = ~byte_in; // Released, so never the last value
  end
endmodule

// *** tb.sv ***
// Self-checking bench for the four-channel serial flag block.
// Assumes the design package, link interface and modules compiled first.
`timescale 1ns/1ps
module tb;
  localparam int NCH = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, module_standby;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [NCH-1:0] int_clk_rise = 4'h0, tx_load = 4'h0, tx_done = 4'h0, overrun_error_flag_set = 4'h0;
  logic [NCH-1:0] per_set = 4'h0, fer_set = 4'h0, ers_set = 4'h0, dma_tx_ack = 4'h0;
  logic [NCH-1:0] dma_rx_ack = 4'h0, sck_pin, rx_last_bit, tx_start_allow, tx_init, rx_enable;
  logic [NCH-1:0] sck_rise, tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq;
  logic [8*NCH-1:0] rx_shift_data, dma_tx_data = 32'h0000_0000, rx_holding_reg, tx_holding_reg;
  logic peer_go = 1'b0, peer_sck, peer_last;
  logic [7:0] peer_byte = 8'h00, peer_data, b;
  logic [8:0] ctl, cnow [4];
  logic [6:0] st [4], m;
  logic [7:0] etx [4];
  logic [9:0] ev;
  logic [7:0] a;
  int errors = 0, checks_done = 0, ch, n;
  // ==========================================
  // Clock, peer and design
  always #2 aclk = ~aclk;
  assign sck_pin = {3'h7, peer_sck};
  assign rx_last_bit = {3'h0, peer_last};
  assign rx_shift_data = {24'h00_0000, peer_data};
  serial_peer peer (.go(peer_go), .byte_in(peer_byte), .sck(peer_sck), .last(peer_last),
    .data(peer_data));
  sci_irq_flags #(.NCH(NCH)) dut (.*);
  // ==========================================
  // Reporting
  task automatic fail(input string msg);
    errors++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic results;
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
      fail(msg);
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp)
      fail("bus response");
  endtask
  // ==========================================
  // Bus master: each channel held until its own handshake
  task automatic axw(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    if (n == 50)
    begin
      fail("write timeout");
      results();
    end
  endtask
  task automatic axr(input logic [7:0] ad, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    cmp_val(s_axi_rdata, exp, "read data");
    cmp_resp(s_axi_rresp, er);
    if (n == 50)
    begin
      fail("read timeout");
      results();
    end
  endtask
  // One-cycle event strobes on one channel
  task automatic pulse(input int c, input logic [9:0] e);
    @(posedge aclk);
    {tx_load[c], tx_done[c], overrun_error_flag_set[c], per_set[c]} <= {e[0], e[1], e[2], e[3]};
    {fer_set[c], ers_set[c], dma_tx_ack[c], dma_rx_ack[c]} <= {e[4], e[5], e[6], e[7]};
    @(posedge aclk);
    {tx_load, tx_done, overrun_error_flag_set, per_set, fer_set, ers_set, dma_tx_ack, dma_rx_ack} <= 32'h0000_0000;
    // Flags settle at the edge above, so look one edge later
    @(posedge aclk);
  endtask
  // Expected requests {error, full, end, empty}; smart card unless block mode
  function automatic logic [3:0] exp_irq(input logic [8:0] c, input logic [6:0] s);
    logic sc;
    logic te;
    sc = c[5] & ~c[6];
    te = c[0] & (sc ? s[1] : s[0]);
    return {c[1] & (s[3] | s[4] | (sc ? s[6] : s[5])), c[1] & s[2], c[2] & s[1] & ~sc & ~te, te};
  endfunction
  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h16dd_eafc));
    for (ch = 0; ch < 4; ch++)
      {cnow[ch], st[ch], etx[ch]} = {9'h000, 7'h03, 8'h00};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_val(module_standby, 1'b1, "standby");
    axw(8'h00, 32'h0000_001f, r);
    cmp_resp(r, 2'b10);
    axr(8'h04, 32'h0000_0000, 2'b10);
    axw(sci_irq_pkg::OFS_STANDBY, 32'h0000_0000, r);
    cmp_resp(r, 2'b00);
    axr(8'h44, 32'h0000_0000, 2'b10);
    axr(8'h04, 32'h0000_0003, 2'b00);
    // Random modes, enables, writes and events across all channels
    for (int i = 0; i < 64; i++)
    begin
      ch = i % 4;
      a = 8'(ch * 16);
      {ctl, m, ev, b} = {9'($urandom), 7'($urandom), 10'($urandom), 8'($urandom)};
      if (cnow[ch][3] && !ctl[3])
        st[ch] = st[ch] | 7'h03;
      axw(a, {23'h00_0000, ctl}, r);
      cnow[ch] = ctl;
      if (ev[8])
      begin
        axw(a + 8'h08, {24'h00_0000, b}, r);
        {etx[ch], st[ch]} = {b, st[ch] & 7'h7c};
      end
      axw(a + 8'h04, {25'h000_0000, m}, r);
      st[ch] = st[ch] & ~m;
      dma_tx_data <= {4{~b}};
      pulse(ch, ev);
      st[ch] = st[ch] & ~(ev[6] ? 7'h03 : 7'h00) & ~(ev[7] ? 7'h04 : 7'h00);
      st[ch] = st[ch] | {ev[5:2], 1'b0, ev[1:0]};
      etx[ch] = ev[6] ? ~b : etx[ch];
      axr(a + 8'h04, {25'h000_0000, st[ch]}, 2'b00);
      cmp_val({rx_error_irq[ch], rx_full_irq[ch], tx_end_irq[ch], tx_empty_irq[ch]},
        exp_irq(ctl, st[ch]), "requests");
      cmp_val(tx_start_allow[ch], ctl[3] & ~st[ch][0] & ~(ctl[7] & |st[ch][5:3]),
        "start allow");
      cmp_val(tx_holding_reg[ch*8+:8], etx[ch], "holding data");
      cmp_val(rx_enable[ch], ctl[4], "receive enable");
    end
    // External-clock frame into channel 0, clock parked high
    axw(8'h00, 32'h0000_0192, r);
    axw(8'h04, 32'h0000_007f, r);
    peer_byte <= 8'hc3;
    peer_go <= 1'b1;
    for (n = 0; n < 400; n++)
    begin
      @(posedge aclk);
      if (rx_full_irq[0])
        break;
    end
    peer_go <= 1'b0;
    if (n == 400)
    begin
      fail("receive timeout");
      results();
    end
    cmp_val(rx_holding_reg[7:0], 8'hc3, "receive data");
    pulse(0, 10'h004);
    cmp_val(rx_error_irq[0], 1'b1, "error request");
    axw(8'h00, 32'h0000_0182, r);
    axr(8'h04, 32'h0000_000c, 2'b00);
    pulse(0, 10'h080);
    cmp_val(rx_full_irq[0], 1'b0, "full after dma");
    // Receive dropped inside the copy window: full flag sets, holding kept
    axw(8'h00, 32'h0000_0192, r);
    axw(8'h04, 32'h0000_007f, r);
    peer_byte <= 8'h3c;
    peer_go <= 1'b1;
    for (n = 0; n < 400 && !(peer_sck && peer_last); n++)
      @(posedge aclk);
    peer_go <= 1'b0;
    if (n == 400)
    begin
      fail("frame timeout");
      results();
    end
    // Write lands as the synchronised last edge is taken, inside the window
    axw(8'h00, 32'h0000_0182, r);
    axr(8'h04, 32'h0000_0004, 2'b00);
    cmp_val(rx_holding_reg[7:0], 8'hc3, "holding kept");
    results();
  end
endmodule
bind sci_irq_flags sci_irq_flags_asserts #(.NCH(NCH)) chk (.*);
